// file: logic/snand_dev_end.sv
// device end of the serial nand link: lane shifter, selection, pause and address capture
`timescale 1ns/1ns
// Summary of operation
// - capture all incoming bits on clock rise
// - change output bits only after clock fall
// - single lane: in on lane0, out lane1
// - work in clock modes zero and three
// - host parks clock per mode at select edges
// - dual: lanes 0,1 both directions, two bits
// - quad: lanes 2,3 join, four bits
// - quad instructions run only with quad enable
// - deselected: all lane drivers released
// - selected: take instructions, deliver read data
// - internal operations survive deselection
// - ignore instructions until first select fall
// - column is 12 bits, valid to 2175
// - row: low six page, upper eleven block
// - pages 2176 bytes, 64 per block, 2048 blocks
// - pause disabled while quad enable set
// - pause starts and ends with clock low
module snand_dev_end (
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  // link
  snand_link_if.dev        LINK,
  // configuration
  input  wire logic        QUAD_ENABLE_I,
  // status
  output logic             SELECTED_O,
  output logic             HOLD_O,
  // instruction
  output logic [7:0]       CMD_O,
  output logic             CMD_VALID_O,
  // address
  output logic [5:0]       ROW_PAGE_O,
  output logic [10:0]      ROW_BLOCK_O,
  output logic             ROW_VALID_O,
  output logic [11:0]      COLUMN_O,
  output logic             COLUMN_OK_O,
  // write data
  output logic [7:0]       RX_BYTE_O,
  output logic             RX_VALID_O,
  // read data
  input  wire logic [7:0]  TX_BYTE_I,
  output logic             TX_TAKE_O
);

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_IGNORE} dev_state_type;

  typedef struct packed {
    logic          cs_meta;
    logic          cs_s;
    logic          cs_d;
    logic          sck_meta;
    logic          sck_s;
    logic          sck_d;
    logic [3:0]    lane_meta;
    logic [3:0]    lane_s;
    dev_state_type state;
    logic [7:0]    opcode;
    logic [7:0]    sh;
    logic [3:0]    bitcnt;
    logic [1:0]    aleft;
    logic [23:0]   addr;
    logic [16:0]   row;
    logic          row_valid;
    logic [11:0]   column;
    logic          column_ok;
    logic          armed;
    logic          hold;
    logic          driving;
    logic [3:0]    out;
    logic [3:0]    oe;
    logic          cmd_valid;
    logic [7:0]    rx_byte;
    logic          rx_valid;
    logic          tx_take;
  } dev_regs_type;

  dev_regs_type r_reg;
  dev_regs_type r_next;

  // ==========================================================================
  // next state
  always_comb begin
    logic       rise;
    logic       fall;
    logic [3:0] w;
    logic [3:0] nb;
    logic [7:0] v;
    logic [7:0] byte_in;
    rise    = 1'b0;
    fall    = 1'b0;
    w       = 4'h1;
    nb      = 4'h0;
    v       = 8'h00;
    byte_in = 8'h00;
    r_next  = r_reg;

    // two flops on every pin before any logic looks at it
    r_next.cs_meta   = LINK.cs_n;
    r_next.cs_s      = r_reg.cs_meta;
    r_next.cs_d      = r_reg.cs_s;
    r_next.sck_meta  = LINK.sck;
    r_next.sck_s     = r_reg.sck_meta;
    r_next.sck_d     = r_reg.sck_s;
    r_next.lane_meta = LINK.lane;
    r_next.lane_s    = r_reg.lane_meta;

    r_next.cmd_valid = 1'b0;
    r_next.row_valid = 1'b0;
    r_next.rx_valid  = 1'b0;
    r_next.tx_take   = 1'b0;

    // edges seen the same way in mode zero and three, idle level does not matter
    rise = r_reg.sck_s & ~r_reg.sck_d;
    fall = ~r_reg.sck_s & r_reg.sck_d;

    // a select fall arms the decoder; cs_s resets high, so a select held low from reset also arms it
    if (r_reg.cs_d && !r_reg.cs_s) begin
      r_next.armed = 1'b1;
    end

    // pause only follows the pin while clock is low; a pin change with clock high waits for the clock fall
    if (r_reg.cs_s || QUAD_ENABLE_I) begin
      r_next.hold = 1'b0;
    end else if (!r_reg.sck_s) begin
      r_next.hold = ~r_reg.lane_s[3];
    end

    if (r_reg.cs_s) begin
      // row, column and user side work are left alone here
      r_next.state   = ST_IDLE;
      r_next.bitcnt  = 4'h0;
      r_next.driving = 1'b0;
    end else if (!r_next.hold) begin
      if (r_reg.state == ST_IDLE) begin
        r_next.state = ST_CMD;
      end
      if (r_reg.state == ST_WDATA || r_reg.state == ST_RDATA) begin
        w = snand_pkg::lane_width(r_reg.opcode);
      end
      nb      = 4'(r_reg.bitcnt + w);
      byte_in = snand_pkg::shift_in(r_reg.sh, r_reg.lane_s, w, 1'b0);
      if (rise && (r_reg.state == ST_CMD || r_reg.state == ST_ADDR || r_reg.state == ST_WDATA)) begin
        r_next.sh     = byte_in;
        r_next.bitcnt = (nb == 4'h8) ? 4'h0 : nb;
        if (nb == 4'h8) begin
          case (r_reg.state)
            ST_CMD: begin
              r_next.opcode    = byte_in;
              r_next.cmd_valid = r_reg.armed && !(snand_pkg::is_quad(byte_in) && !QUAD_ENABLE_I);
              r_next.aleft     = snand_pkg::addr_bytes(byte_in);
              if (!r_reg.armed) begin
                r_next.state = ST_IGNORE;
              end else if (snand_pkg::is_quad(byte_in) && !QUAD_ENABLE_I) begin
                r_next.state = ST_IGNORE;
              end else if (snand_pkg::addr_bytes(byte_in) != 2'h0) begin
                r_next.state = ST_ADDR;
              end else begin
                r_next.state = ST_IGNORE;
              end
            end
            ST_ADDR: begin
              r_next.addr  = {r_reg.addr[15:0], byte_in};
              r_next.aleft = 2'(r_reg.aleft - 2'h1);
              if (r_reg.aleft == 2'h1) begin
                if (r_reg.opcode == snand_pkg::OP_ROW_SELECT) begin
                  r_next.row       = {r_reg.addr[8:0], byte_in};
                  r_next.row_valid = 1'b1;
                  r_next.state     = ST_IGNORE;
                end else begin
                  // the upper four bits of the first byte fall away
                  r_next.column = {r_reg.addr[3:0], byte_in};
                  r_next.state  = snand_pkg::is_read(r_reg.opcode) ? ST_RDATA : ST_WDATA;
                end
              end
            end
            default: begin
              r_next.rx_byte  = byte_in;
              r_next.rx_valid = 1'b1;
              r_next.column   = 12'(r_reg.column + 12'h001);
            end
          endcase
        end
      end
      // read data goes out on the fall so the host finds it stable on the rise
      if (fall && r_reg.state == ST_RDATA) begin
        v = (r_reg.bitcnt == 4'h0) ? TX_BYTE_I : r_reg.sh;
        if (r_reg.bitcnt == 4'h0) begin
          r_next.tx_take = 1'b1;
          if (r_reg.driving) begin
            r_next.column = 12'(r_reg.column + 12'h001);
          end
        end
        r_next.out     = snand_pkg::lanes_out(v, w);
        r_next.sh      = 8'(v << w);
        r_next.bitcnt  = (nb == 4'h8) ? 4'h0 : nb;
        r_next.driving = 1'b1;
      end
    end

    // lanes released on deselect and for the whole pause
    r_next.oe = (r_next.driving && !r_next.hold && r_next.state == ST_RDATA) ?
                snand_pkg::lane_mask(snand_pkg::lane_width(r_next.opcode), 1'b1) : 4'h0;
    r_next.column_ok = (r_next.column <= snand_pkg::COL_LAST_VALID);
  end

  // ==========================================================================
  // state register
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      r_reg           <= '0;
      r_reg.cs_meta   <= 1'b1;
      r_reg.cs_s      <= 1'b1;
      r_reg.state     <= ST_IDLE;
      r_reg.column_ok <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // outputs
  assign LINK.dev_out = r_reg.out;
  assign LINK.dev_oe  = r_reg.oe;
  assign SELECTED_O   = ~r_reg.cs_s;
  assign HOLD_O       = r_reg.hold;
  assign CMD_O        = r_reg.opcode;
  assign CMD_VALID_O  = r_reg.cmd_valid;
  assign ROW_PAGE_O   = r_reg.row[5:0];
  assign ROW_BLOCK_O  = r_reg.row[16:6];
  assign ROW_VALID_O  = r_reg.row_valid;
  assign COLUMN_O     = r_reg.column;
  assign COLUMN_OK_O  = r_reg.column_ok;
  assign RX_BYTE_O    = r_reg.rx_byte;
  assign RX_VALID_O   = r_reg.rx_valid;
  assign TX_TAKE_O    = r_reg.tx_take;

endmodule

// file: logic/snand_host_end.sv
// host end of the serial nand link: clock divider, select and lane sequencer
`timescale 1ns/1ns
module snand_host_end (
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  // link
  snand_link_if.host       LINK,
  // mode, high selects clock mode three
  input  wire logic        MODE3_I,
  // command
  input  wire logic        CMD_VALID_I,
  output logic             CMD_READY_O,
  input  wire logic [7:0]  CMD_OPCODE_I,
  input  wire logic [23:0] CMD_ADDR_I,
  input  wire logic [11:0] CMD_LEN_I,
  // write data
  input  wire logic [7:0]  WR_BYTE_I,
  output logic             WR_TAKE_O,
  // read data and completion
  output logic [7:0]       RD_BYTE_O,
  output logic             RD_VALID_O,
  output logic             DONE_O
);

  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_TAIL, HS_GAP} host_state_type;
  typedef enum logic [1:0] {HP_CMD, HP_ADDR, HP_DATA} host_part_type;

  typedef struct packed {
    logic [3:0]     lane_meta;
    logic [3:0]     lane_s;
    host_state_type state;
    host_part_type  part;
    logic           mode3;
    logic [7:0]     div;
    logic           sck;
    logic           cs_n;
    logic [7:0]     opcode;
    logic [23:0]    addr;
    logic [1:0]     aleft;
    logic [11:0]    dleft;
    logic [7:0]     sh;
    logic [3:0]     bitcnt;
    logic           pending;
    logic [3:0]     out;
    logic [3:0]     oe;
    logic           ready;
    logic           wr_take;
    logic [7:0]     rd_byte;
    logic           rd_valid;
    logic           done;
  } host_regs_type;

  host_regs_type r_reg;
  host_regs_type r_next;

  // ==========================================================================
  // next state
  always_comb begin
    logic       tick;
    logic [3:0] w;
    logic [3:0] nb;
    logic [3:0] m;
    logic       rd;
    tick   = 1'b0;
    w      = 4'h1;
    nb     = 4'h0;
    m      = 4'h0;
    rd     = 1'b0;
    r_next = r_reg;

    r_next.lane_meta = LINK.lane;
    r_next.lane_s    = r_reg.lane_meta;
    r_next.wr_take   = 1'b0;
    r_next.rd_valid  = 1'b0;
    r_next.done      = 1'b0;

    tick = (r_reg.div == 8'(snand_pkg::SCK_HALF_CYCLES - 8'h01));
    r_next.div = (r_reg.state == HS_IDLE || tick) ? 8'h00 : 8'(r_reg.div + 8'h01);
    if (r_reg.part == HP_DATA) begin
      w = snand_pkg::lane_width(r_reg.opcode);
    end
    rd = snand_pkg::is_read(r_reg.opcode) && (r_reg.part == HP_DATA);
    nb = 4'(r_reg.bitcnt + w);

    case (r_reg.state)
      HS_IDLE: begin
        // idle clock level set by the mode while deselected
        r_next.sck   = MODE3_I;
        r_next.cs_n  = 1'b1;
        r_next.ready = 1'b1;
        r_next.out   = snand_pkg::HOST_IDLE_OUT;
        r_next.oe    = snand_pkg::HOST_IDLE_OE;
        if (CMD_VALID_I && r_reg.ready) begin
          r_next.ready   = 1'b0;
          r_next.mode3   = MODE3_I;
          r_next.cs_n    = 1'b0;
          r_next.opcode  = CMD_OPCODE_I;
          r_next.aleft   = snand_pkg::addr_bytes(CMD_OPCODE_I);
          r_next.dleft   = CMD_LEN_I;
          r_next.part    = HP_CMD;
          r_next.sh      = CMD_OPCODE_I;
          r_next.bitcnt  = 4'h0;
          r_next.pending = 1'b0;
          r_next.out     = snand_pkg::HOST_IDLE_OUT | snand_pkg::lanes_out(CMD_OPCODE_I, 4'h1);
          r_next.oe      = snand_pkg::HOST_IDLE_OE | 4'h1;
          case (snand_pkg::addr_bytes(CMD_OPCODE_I))
            2'h3:    r_next.addr = CMD_ADDR_I;
            2'h2:    r_next.addr = {CMD_ADDR_I[15:0], 8'h00};
            default: r_next.addr = {CMD_ADDR_I[7:0], 16'h0000};
          endcase
          r_next.state = HS_RUN;
        end
      end
      HS_RUN: begin
        if (tick) begin
          r_next.sck = ~r_reg.sck;
          if (!r_reg.sck) begin
            // rising: the device samples, the host samples read data
            r_next.pending = 1'b1;
            if (rd) begin
              r_next.sh = snand_pkg::shift_in(r_reg.sh, r_reg.lane_s, w, 1'b1);
            end
            r_next.bitcnt = (nb == 4'h8) ? 4'h0 : nb;
            if (nb == 4'h8) begin
              if (rd) begin
                r_next.rd_byte  = snand_pkg::shift_in(r_reg.sh, r_reg.lane_s, w, 1'b1);
                r_next.rd_valid = 1'b1;
              end
              if (r_reg.part == HP_CMD && r_reg.aleft != 2'h0) begin
                r_next.part = HP_ADDR;
              end else if (r_reg.part == HP_ADDR && r_reg.aleft != 2'h1) begin
                r_next.aleft = 2'(r_reg.aleft - 2'h1);
              end else if (r_reg.part != HP_DATA && r_reg.dleft != 12'h000) begin
                r_next.part = HP_DATA;
              end else if (r_reg.part == HP_DATA && r_reg.dleft != 12'h001) begin
                r_next.dleft = 12'(r_reg.dleft - 12'h001);
              end else begin
                r_next.state = HS_TAIL;
              end
            end
          end else if (r_reg.pending) begin
            // falling: next bits go out, width follows the part just entered
            r_next.pending = 1'b0;
            w = (r_next.part == HP_DATA) ? snand_pkg::lane_width(r_reg.opcode) : 4'h1;
            if (r_reg.bitcnt == 4'h0 && r_next.part == HP_ADDR) begin
              r_next.sh   = r_reg.addr[23:16];
              r_next.addr = {r_reg.addr[15:0], 8'h00};
            end else if (r_reg.bitcnt == 4'h0 && !snand_pkg::is_read(r_reg.opcode)) begin
              r_next.sh      = WR_BYTE_I;
              r_next.wr_take = 1'b1;
            end else if (r_reg.bitcnt != 4'h0 && !rd) begin
              // read data is shifted in on the rise only, a second shift would split the bits
              r_next.sh = 8'(r_reg.sh << w);
            end
            m = snand_pkg::lane_mask(w, 1'b0);
            if (r_next.part == HP_DATA && snand_pkg::is_read(r_reg.opcode)) begin
              // turn the lanes over to the device before its first fall output
              r_next.oe = snand_pkg::is_quad(r_reg.opcode) ? 4'h0 : snand_pkg::HOST_IDLE_OE;
            end else begin
              // write protect and pause lanes held high unless quad data uses them
              r_next.out = (snand_pkg::HOST_IDLE_OUT & ~m) | (snand_pkg::lanes_out(r_next.sh, w) & m);
              r_next.oe  = snand_pkg::HOST_IDLE_OE | m;
            end
          end
        end
      end
      HS_TAIL: begin
        if (tick) begin
          if (r_reg.sck && !r_reg.mode3) begin
            r_next.sck = 1'b0;
          end else begin
            // after a quad read the device still drives for a few cycles; wait for it
            r_next.cs_n  = 1'b1;
            r_next.out   = snand_pkg::HOST_IDLE_OUT;
            r_next.oe    = snand_pkg::HOST_IDLE_OE & r_reg.oe;
            r_next.state = HS_GAP;
          end
        end
      end
      default: begin
        if (r_reg.div == snand_pkg::LANE_TAKEBACK_CYCLES) begin
          r_next.out = snand_pkg::HOST_IDLE_OUT;
          r_next.oe  = snand_pkg::HOST_IDLE_OE;
        end
        if (tick) begin
          r_next.done  = 1'b1;
          r_next.state = HS_IDLE;
        end
      end
    endcase
  end

  // ==========================================================================
  // state register
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      r_reg       <= '0;
      r_reg.cs_n  <= 1'b1;
      r_reg.state <= HS_IDLE;
      r_reg.out   <= snand_pkg::HOST_IDLE_OUT;
      r_reg.oe    <= snand_pkg::HOST_IDLE_OE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // outputs
  assign LINK.cs_n     = r_reg.cs_n;
  assign LINK.sck      = r_reg.sck;
  assign LINK.host_out = r_reg.out;
  assign LINK.host_oe  = r_reg.oe;
  assign CMD_READY_O   = r_reg.ready;
  assign WR_TAKE_O     = r_reg.wr_take;
  assign RD_BYTE_O     = r_reg.rd_byte;
  assign RD_VALID_O    = r_reg.rd_valid;
  assign DONE_O        = r_reg.done;

endmodule

// file: logic/snand_link_if.sv
// link wires between the serial nand host and device ends
`timescale 1ns/1ns
interface snand_link_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] host_out;
  logic [3:0] host_oe;
  logic [3:0] dev_out;
  logic [3:0] dev_oe;
  logic [3:0] lane;

  // resolved lane level, pulled high when nobody drives
  generate
    for (genvar i = 0; i < 4; i++) begin : g_lane
      assign lane[i] = dev_oe[i] ? dev_out[i] : (host_oe[i] ? host_out[i] : 1'b1);
    end
  endgenerate

  modport dev  (input cs_n, sck, lane, output dev_out, dev_oe);
  modport host (output cs_n, sck, host_out, host_oe, input lane);
endinterface

// file: logic/snand_pkg.sv
// shared constants, opcodes and lane helpers for both serial nand link ends
package snand_pkg;

  // ==========================================================================
  // timing
  localparam int SYS_CLK_MHZ    = 125;
  localparam int SCK_PERIOD_NS  = 160;
  localparam logic [7:0] SCK_HALF_CYCLES = 8'(SCK_PERIOD_NS * SYS_CLK_MHZ / 2000);
  // cycles after deselect before the host drives the lanes again
  localparam logic [7:0] LANE_TAKEBACK_CYCLES = 8'h04;

  // ==========================================================================
  // geometry
  localparam int COL_ADDR_BITS    = 12;
  localparam int PAGE_DATA_BYTES  = 2048;
  localparam int PAGE_SPARE_BYTES = 128;
  localparam int PAGES_PER_BLOCK  = 64;
  localparam int BLOCK_COUNT      = 2048;
  localparam int ROW_ADDR_BITS    = 17;
  localparam int ROW_PAGE_BITS    = 6;
  // last byte that exists in a page, beyond it is out of bounds
  localparam logic [11:0] COL_LAST_VALID = 12'(PAGE_DATA_BYTES + PAGE_SPARE_BYTES - 1);

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_READ_X1    = 8'h03;
  localparam logic [7:0] OP_READ_X2    = 8'h3B;
  localparam logic [7:0] OP_READ_X4    = 8'h6B;
  localparam logic [7:0] OP_WRITE_X1   = 8'h02;
  localparam logic [7:0] OP_WRITE_X2   = 8'hA2;
  localparam logic [7:0] OP_WRITE_X4   = 8'h32;
  localparam logic [7:0] OP_ROW_SELECT = 8'h13;

  // ==========================================================================
  // reset values
  localparam logic [3:0] HOST_IDLE_OUT = 4'hC;
  localparam logic [3:0] HOST_IDLE_OE  = 4'hC;

  // ==========================================================================
  // decoders
  function automatic logic is_quad(input logic [7:0] op);
    is_quad = (op == OP_READ_X4) || (op == OP_WRITE_X4);
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OP_READ_X1) || (op == OP_READ_X2) || (op == OP_READ_X4);
  endfunction

  function automatic logic [3:0] lane_width(input logic [7:0] op);
    if (op == OP_READ_X2 || op == OP_WRITE_X2) begin
      lane_width = 4'h2;
    end else if (is_quad(op)) begin
      lane_width = 4'h4;
    end else begin
      lane_width = 4'h1;
    end
  endfunction

  function automatic logic [1:0] addr_bytes(input logic [7:0] op);
    if (op == OP_ROW_SELECT) begin
      addr_bytes = 2'h3;
    end else if (is_read(op) || op == OP_WRITE_X1 || op == OP_WRITE_X2 || op == OP_WRITE_X4) begin
      addr_bytes = 2'h2;
    end else begin
      addr_bytes = 2'h0;
    end
  endfunction

  // msb first; single lane listens on lane 0, or lane 1 when reading the device
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] ln,
                                          input logic [3:0] w, input logic from_so);
    case (w)
      4'h4:    shift_in = {sh[3:0], ln[3], ln[2], ln[1], ln[0]};
      4'h2:    shift_in = {sh[5:0], ln[1], ln[0]};
      default: shift_in = {sh[6:0], from_so ? ln[1] : ln[0]};
    endcase
  endfunction

  function automatic logic [3:0] lanes_out(input logic [7:0] v, input logic [3:0] w);
    case (w)
      4'h4:    lanes_out = v[7:4];
      4'h2:    lanes_out = {2'b00, v[7:6]};
      default: lanes_out = {2'b00, v[7], v[7]};
    endcase
  endfunction

  function automatic logic [3:0] lane_mask(input logic [3:0] w, input logic dev);
    case (w)
      4'h4:    lane_mask = 4'hF;
      4'h2:    lane_mask = 4'h3;
      default: lane_mask = dev ? 4'h2 : 4'h1;
    endcase
  endfunction

endpackage

// file: tb/serial_nand_host_interface_tb.sv
// random and corner transfers across both ends of the serial nand link
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module serial_nand_host_interface_tb;
  logic        sys_clk, rst_n, mode3, qe, cmd_valid, cmd_ready, wr_take, rd_valid, done, sel, hold;
  logic        cmd_v, row_v, col_ok, rx_v, tx_take;
  logic [7:0]  op_i, wr_byte, rd_byte, cmd_o, rx_byte, tx_byte, cmd_last;
  logic [23:0] addr;
  logic [11:0] len, col;
  logic [5:0]  page;
  logic [10:0] blk;
  logic [7:0]  wdata[4], tdata[4], rxq[$], rdq[$];
  int          widx, tidx, cmd_cnt, rows, mismatches, checked, k;
  snand_link_if link ();
  snand_host_end i_snand_host_end (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .LINK(link), .MODE3_I(mode3),
    .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .CMD_OPCODE_I(op_i), .CMD_ADDR_I(addr), .CMD_LEN_I(len),
    .WR_BYTE_I(wr_byte), .WR_TAKE_O(wr_take), .RD_BYTE_O(rd_byte), .RD_VALID_O(rd_valid), .DONE_O(done));
  snand_dev_end i_snand_dev_end (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .LINK(link), .QUAD_ENABLE_I(qe),
    .SELECTED_O(sel), .HOLD_O(hold), .CMD_O(cmd_o), .CMD_VALID_O(cmd_v), .ROW_PAGE_O(page), .ROW_BLOCK_O(blk),
    .ROW_VALID_O(row_v), .COLUMN_O(col), .COLUMN_OK_O(col_ok), .RX_BYTE_O(rx_byte), .RX_VALID_O(rx_v),
    .TX_BYTE_I(tx_byte), .TX_TAKE_O(tx_take));
  snand_link_props i_snand_link_props (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(link.cs_n), .sck(link.sck),
    .host_out(link.host_out), .host_oe(link.host_oe), .dev_out(link.dev_out), .dev_oe(link.dev_oe),
    .lane(link.lane));
  // ==========================================================================
  // clock, data feeds and capture
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  assign wr_byte = wdata[widx % 4];
  assign tx_byte = tdata[tidx % 4];
  // indexes restart at command take so the first byte is ready before the first fall
  always @(posedge sys_clk) begin
    widx <= (cmd_valid && cmd_ready) ? 0 : widx + int'(wr_take);
    tidx <= (cmd_valid && cmd_ready) ? 0 : tidx + int'(tx_take);
    if (rx_v === 1'b1) rxq.push_back(rx_byte);
    if (rd_valid === 1'b1) rdq.push_back(rd_byte);
    if (row_v === 1'b1) rows++;
    if (cmd_v === 1'b1) begin
      cmd_cnt++;
      cmd_last = cmd_o;
    end
  end
  // ==========================================================================
  // expectations
  function automatic logic quad_op(input logic [7:0] op);
    return op == snand_pkg::OP_READ_X4 || op == snand_pkg::OP_WRITE_X4;
  endfunction
  function automatic logic wr_op(input logic [7:0] op);
    return op == snand_pkg::OP_WRITE_X1 || op == snand_pkg::OP_WRITE_X2 || op == snand_pkg::OP_WRITE_X4;
  endfunction
  function automatic logic ok_col(input logic [11:0] c);
    return c <= 12'h87F;
  endfunction
  // ==========================================================================
  // one command through both ends
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [11:0] n, input logic m3, input logic q);
    logic go;
    go = !(quad_op(op) && !q);
    for (int i = 0; i < 4; i++) begin
      wdata[i] = 8'($urandom);
      tdata[i] = 8'($urandom);
    end
    rxq.delete();
    rdq.delete();
    cmd_cnt = 0;
    rows = 0;
    // mode settles while idle so the clock is parked before the select falls
    {mode3, qe} = {m3, q};
    repeat (2) @(posedge sys_clk);
    #1 {op_i, addr, len, cmd_valid} = {op, a, n, 1'b1};
    k = 0;
    while (cmd_ready !== 1'b1 && k < 5000) begin
      @(posedge sys_clk);
      #1 k++;
    end
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      @(posedge sys_clk);
      #1 k++;
    end
    `CHK(k < 20000, 1'b1)
    `CHK(sel, 1'b0)
    `CHK(cmd_cnt, int'(go))
    if (go) `CHK(cmd_last, op)
    if (wr_op(op)) begin
      `CHK(rxq.size(), go ? int'(n) : 0)
      foreach (rxq[i]) `CHK(rxq[i], wdata[i])
      if (go) `CHK(col, 12'(a[11:0] + n))
      if (go) `CHK(col_ok, ok_col(12'(a[11:0] + n)))
    end else if (op == snand_pkg::OP_ROW_SELECT) begin
      `CHK({blk, page}, a[16:0])
      `CHK(rows, 1)
    end else if (go) begin
      `CHK(rdq.size(), int'(n))
      foreach (rdq[i]) `CHK(rdq[i], tdata[i])
    end
    $display("test op %h mode %0d quad %0d ended", op, m3, q);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    logic [7:0] ops[6];
    ops = '{8'h03, 8'h3B, 8'h6B, 8'h02, 8'hA2, 8'h32};
    {rst_n, mode3, qe, cmd_valid, op_i, addr, len, mismatches, checked} = '0;
    {widx, tidx} = '0;
    void'($urandom(32'hCF19));
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    `CHK(col_ok, 1'b1)
    repeat (2) @(posedge sys_clk);
    #1 run(snand_pkg::OP_WRITE_X4, 24'h000010, 12'h002, 1'b0, 1'b0); // refused without quad enable
    run(snand_pkg::OP_WRITE_X1, 24'h00087F, 12'h001, 1'b0, 1'b1); // last valid byte, then out of bounds
    run(snand_pkg::OP_READ_X1, 24'h000100, 12'h000, 1'b0, 1'b1);
    run(snand_pkg::OP_ROW_SELECT, 24'h01FFC0, 12'h000, 1'b0, 1'b1);
    // mode zero first: the idle clock level only flips once
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 6; i++) begin
        run(ops[i], 24'($urandom_range(0, 2171)), 12'($urandom_range(1, 4)), m[0], 1'b1);
      end
      run(snand_pkg::OP_ROW_SELECT, 24'($urandom) & 24'h01FFFF, 12'h000, m[0], 1'b1);
    end
    close_out();
  end
  initial begin
    #(8 * 90000);
    mismatches++;
    close_out();
  end
endmodule

// file: tb/snand_link_props.sv
// link wire assertions between host end and device end
`timescale 1ns/1ns
module snand_link_props (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // link wires
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic [3:0] host_out,
  input  wire logic [3:0] host_oe,
  input  wire logic [3:0] dev_out,
  input  wire logic [3:0] dev_oe,
  input  wire logic [3:0] lane
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // lane ownership
  a_no_lane_fight: assert property ((host_oe & dev_oe) == 4'h0) else $error("two drivers on a lane");
  a_dev_oe_shape: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("odd lane set");
  // sync delay gives the device about three cycles to let go
  a_desel_lanes_free: assert property (cs_n [*5] |-> dev_oe == 4'h0 && lane == 4'hF)
    else $error("device drives while deselected");
  a_host_idle_high: assert property (cs_n [*8] |-> host_oe == 4'hC && host_out == 4'hC)
    else $error("host idle lanes wrong");
  // ==========================================================================
  // clock and edges
  // the idle level may follow a mode change while deselected, but not at the select edge
  a_cs_fall_sck: assert property ($fell(cs_n) |-> $stable(sck) ##1 $stable(sck))
    else $error("clock moves at select");
  a_cs_rise_sck: assert property ($rose(cs_n) |-> $stable(sck) ##1 $stable(sck))
    else $error("clock moves at deselect");
  a_sck_high_width: assert property ($rose(sck) |-> sck [*8]) else $error("clock high too short");
  a_host_rise_stable: assert property ($rose(sck) |-> $stable(host_out & host_oe))
    else $error("host lanes move at rise");
  // masked compare so a released lane never counts as a change
  a_dev_out_on_low: assert property (!cs_n && $stable(dev_oe) && $changed(dev_out & dev_oe) |-> !sck)
    else $error("device lanes move with clock high");
  // ==========================================================================
  // scenario cover
  c_quad_out: cover property (!cs_n && dev_oe == 4'hF);
  c_dual_out: cover property (!cs_n && dev_oe == 4'h3);
  c_single_out: cover property (!cs_n && dev_oe == 4'h2);
endmodule
